//--- core/calendar_clock_module_control.sv
// Overview of operation
// R1: the trim field is a signed 10-bit value and zero means no correction.
// R2: a positive trim N adds N timekeeping pulses once per minute (1..511).
// R3: a negative trim removes its magnitude in pulses per minute (1..512).
// R4: the module runs while the enable bit 15 is one, else it is held.
// R5: the enable bit takes a write only while write_unlock is one.
// R6: write_unlock can be set only while the unlock sequence is enabled.
// R7: with idle_stop set, the bus clock to the module is cut in Idle mode.
// R8: pin_source_select picks the seconds clock (1) or alarm pulse (0).
// R9: the chosen signal drives the pin only while pin_output_enable is one.
// R10: clock_running_flag reads one while the timekeeping clock runs.
// R11: half_second_flag is read-only and a seconds write clears it.
// R12: rtc_control returns to its defaults only on power-on reset.
// R13: software avoids access in the cycle after clearing the enable bit.
// R14: unimplemented bits of rtc_control ignore writes and read zero.
// R15: the trim is applied once per minute, at the minute rollover.
module calendar_clock_module_control #(
  parameter int unsigned PULSES_PER_SEC = calendar_clock_module_pkg::PPS_DEF
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire calendar_clock_module_pkg::calendar_clock_module_apb_req_s apb_req,
  output      calendar_clock_module_pkg::calendar_clock_module_apb_rsp_s apb_rsp,
  input  wire logic                    tk_clk_pin,
  input  wire logic                    idle_mode,
  input  wire logic                    unlock_seq_en,
  input  wire logic                    alarm_pulse,
  output      logic                    bus_clk_en,
  output      logic                    module_on,
  output      logic                    rtc_pin_out,
  output      logic                    rtc_pin_drive
);
  import calendar_clock_module_pkg::*;

  // half-second length in timekeeping pulses; the prescaler counts
  // 0..PRE_LAST and the half-second flag toggles at its end
  localparam int unsigned HALF_CNT = PULSES_PER_SEC / 2;
  localparam logic [15:0] PRE_LAST = 16'(HALF_CNT - 1);
  // a sync window longer than the half second would wrap below zero;
  // open it from the start of the half second instead
  localparam int unsigned SYNC_FROM =
    (HALF_CNT > SYNC_WIN) ? HALF_CNT - SYNC_WIN : 0;
  localparam logic [15:0] PRE_SYNC = 16'(SYNC_FROM);

  // magnitude of a two's-complement trim, 1..512 for negatives
  // shared by the skip count and the forward load of the prescaler
  function automatic logic [9:0] trim_mag(input logic [CAL_W-1:0] t);
    logic [CAL_W-1:0] neg;
    neg = ~t + 10'h001;
    trim_mag = t[CAL_W-1] ? neg : t;
  endfunction

  // control fields
  logic [CAL_W-1:0] cal_reg;
  logic [CAL_W-1:0] cal_next;
  logic             on_reg;
  logic             on_next;
  logic             idle_stop_reg;
  logic             idle_stop_next;
  logic             sel_reg;
  logic             sel_next;
  logic             unlock_reg;
  logic             unlock_next;
  logic             oe_reg;
  logic             oe_next;

  // timekeeping state
  calendar_clock_module_tk_e         tk_reg;
  calendar_clock_module_tk_e         tk_next;
  logic [15:0]      pre_reg;
  logic [15:0]      pre_next;
  logic [9:0]       skip_reg;
  logic [9:0]       skip_next;
  logic             half_reg;
  logic             half_next;
  logic [SEC_W-1:0] sec_reg;
  logic [SEC_W-1:0] sec_next;

  // pin synchroniser and edge history
  logic             tk_s1_reg;
  logic             tk_s2_reg;
  logic             tk_s3_reg;

  // outputs from flip-flops
  logic [31:0]      prdata_reg;
  logic [31:0]      prdata_next;
  logic             pin_out_reg;
  logic             pin_drive_reg;
  logic             bus_clk_en_reg;

  // bus decode
  wire              setup_ph  = apb_req.psel & ~apb_req.penable;
  wire              access_ph = apb_req.psel & apb_req.penable;
  wire              hit_ctrl  = apb_req.paddr == CALENDAR_CLOCK_MODULE_CTRL_OFS;
  wire              hit_time  = apb_req.paddr == CALENDAR_CLOCK_MODULE_TIME_OFS;
  wire              hit_any   = hit_ctrl | hit_time;
  wire              wr_en     = access_ph & apb_req.pwrite;
  wire              wr_ctrl   = wr_en & hit_ctrl;
  wire              wr_time   = wr_en & hit_time;
  wire [31:0]       wdata     = apb_req.pwdata;

  // state of the clock gate and the running module
  wire              clk_cut   = idle_stop_reg & idle_mode;
  wire              running   = on_reg & ~clk_cut;
  // rising edges only; a pin held high is one pulse, not many
  wire              tk_rise   = tk_s2_reg & ~tk_s3_reg;
  wire              tk_step   = running & tk_rise;
  wire              pre_end   = pre_reg == PRE_LAST;
  wire              sec_end   = half_reg & pre_end;
  wire              min_end   = sec_end & (sec_reg == SEC_LAST);
  // warns software that a rollover is near, when a time read may tear
  wire              sync_win  = running & half_reg & (pre_reg >= PRE_SYNC);
  wire [9:0]        cal_mag   = trim_mag(cal_reg);
  wire              cal_neg   = cal_reg[CAL_W-1];
  wire              cal_zero  = cal_reg == CAL_RESET;
  // a trim beyond the half-second length would run the prescaler past its
  // end and around 16 bits; clamp it to one shortened half second instead
  wire [15:0]       trim_ext  = {6'h00, cal_mag};
  wire [15:0]       trim_load = (trim_ext > PRE_LAST) ? PRE_LAST : trim_ext;
  wire              pin_src   = sel_reg ? half_reg : alarm_pulse;

  // read view; reserved positions forced to zero by the mask
  wire [31:0]       ctrl_raw  = {6'h00, cal_reg, on_reg, 1'b0,
                                 idle_stop_reg, 5'h00, sel_reg, running,
                                 2'b00, unlock_reg, sync_win, half_reg,
                                 oe_reg};
  // R14: reserved read zero
  wire [31:0]       ctrl_rd   = ctrl_raw & CTRL_IMPL_MASK;
  wire [31:0]       time_rd   = {17'h0_0000, sec_reg, 8'h00};

  // control register writes
  always_comb begin
    cal_next       = cal_reg;
    on_next        = on_reg;
    idle_stop_next = idle_stop_reg;
    sel_next       = sel_reg;
    unlock_next    = unlock_reg;
    oe_next        = oe_reg;
    if (wr_ctrl) begin
      // R1: signed trim stored
      cal_next       = wdata[CAL_LSB +: CAL_W];
      idle_stop_next = wdata[IDLE_STOP_BIT];
      sel_next       = wdata[SEL_BIT];
      oe_next        = wdata[OE_BIT];
      // R5: enable guarded by unlock
      // the unlock value before this write counts, so one write cannot
      // both unlock and start the module
      if (unlock_reg) begin
        on_next = wdata[ON_BIT];
      end
      // clearing is always allowed; setting needs the sequence or a set bit
      // R6: set needs unlock sequence
      unlock_next = wdata[UNLOCK_BIT] & (unlock_seq_en | unlock_reg);
    end
  end

  // prescaler, half-second phase and seconds count
  always_comb begin
    tk_next   = tk_reg;
    pre_next  = pre_reg;
    skip_next = skip_reg;
    half_next = half_reg;
    sec_next  = sec_reg;
    // R4: counting only while enabled
    if (tk_step) begin
      unique case (tk_reg)
        TK_SKIP: begin
          // prescaler and seconds hold still while pulses are eaten
          // R3: eat pulses for negative trim
          skip_next = skip_reg - 10'h001;
          if (skip_reg == 10'h001) begin
            tk_next = TK_COUNT;
          end
        end
        TK_COUNT: begin
          if (pre_end) begin
            pre_next  = PRE_RESET;
            half_next = ~half_reg;
          end else begin
            pre_next = pre_reg + 16'h0001;
          end
          // seconds step as the half-second flag falls
          if (sec_end) begin
            sec_next = sec_reg + 7'h01;
          end
          // R15: trim at minute rollover
          if (min_end) begin
            sec_next = SEC_RESET;
            if (!cal_zero && !cal_neg) begin
              // R2: skip ahead adds pulses
              pre_next = trim_load;
            end
            if (cal_neg) begin
              tk_next   = TK_SKIP;
              skip_next = cal_mag;
            end
          end
        end
      endcase
    end
    // a seconds write restarts the second and drops a pending skip,
    // so a skip left from the last rollover never eats pulses of the newly written time
    // R11: seconds write clears half flag
    if (wr_time) begin
      sec_next  = wdata[SEC_LSB +: SEC_W];
      half_next = 1'b0;
      pre_next  = PRE_RESET;
      tk_next   = TK_COUNT;
      skip_next = SKIP_RESET;
    end
  end

  // read data is captured in the setup phase and held for the access
  assign prdata_next = !setup_ph ? prdata_reg :
                       hit_ctrl  ? ctrl_rd    :
                       hit_time  ? time_rd    : 32'h0000_0000;

  // R12: only power-on reset clears control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_reg       <= CTRL_RESET[CAL_LSB +: CAL_W];
      on_reg        <= CTRL_RESET[ON_BIT];
      idle_stop_reg <= CTRL_RESET[IDLE_STOP_BIT];
      sel_reg       <= CTRL_RESET[SEL_BIT];
      unlock_reg    <= CTRL_RESET[UNLOCK_BIT];
      oe_reg        <= CTRL_RESET[OE_BIT];
    end else begin
      cal_reg       <= cal_next;
      on_reg        <= on_next;
      idle_stop_reg <= idle_stop_next;
      sel_reg       <= sel_next;
      unlock_reg    <= unlock_next;
      oe_reg        <= oe_next;
    end
  end

  // timekeeping registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tk_reg   <= TK_COUNT;
      pre_reg  <= PRE_RESET;
      skip_reg <= SKIP_RESET;
      half_reg <= 1'b0;
      sec_reg  <= SEC_RESET;
    end else begin
      tk_reg   <= tk_next;
      pre_reg  <= pre_next;
      skip_reg <= skip_next;
      half_reg <= half_next;
      sec_reg  <= sec_next;
    end
  end

  // two stages before any logic reads the pin, third for edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tk_s1_reg <= 1'b0;
      tk_s2_reg <= 1'b0;
      tk_s3_reg <= 1'b0;
    end else begin
      tk_s1_reg <= tk_clk_pin;
      tk_s2_reg <= tk_s1_reg;
      tk_s3_reg <= tk_s2_reg;
    end
  end

  // registered outputs; pin low and undriven when not enabled
  // holding the level low too keeps the pin quiet if it is driven later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg     <= 32'h0000_0000;
      pin_out_reg    <= 1'b0;
      pin_drive_reg  <= 1'b0;
      bus_clk_en_reg <= 1'b1;
    end else begin
      prdata_reg     <= prdata_next;
      // R8: pin source select
      // R9: pin enable gates
      pin_out_reg    <= oe_reg & pin_src;
      pin_drive_reg  <= oe_reg;
      // R7: idle cuts bus clock
      bus_clk_en_reg <= ~clk_cut;
    end
  end

  // the apb side is never stalled; a cut bus clock is signalled out,
  // and registers still answer so a master can never hang on us
  assign apb_rsp = '{
    prdata:  prdata_reg,
    pready:  1'b1,
    pslverr: access_ph & ~hit_any
  };

  // module_on is the same signal as the running flag, so both agree
  // R10: running flag on outputs
  assign module_on     = running;
  assign bus_clk_en    = bus_clk_en_reg;
  assign rtc_pin_out   = pin_out_reg;
  assign rtc_pin_drive = pin_drive_reg;

endmodule

//--- core/calendar_clock_module_pkg.sv
package calendar_clock_module_pkg;

  // register byte offsets on the apb
  localparam logic [11:0] CALENDAR_CLOCK_MODULE_CTRL_OFS = 12'h000;
  localparam logic [11:0] CALENDAR_CLOCK_MODULE_TIME_OFS = 12'h004;

  // field positions of rtc_control
  localparam int unsigned CAL_LSB       = 16;
  localparam int unsigned CAL_W         = 10;
  localparam int unsigned ON_BIT        = 15;
  localparam int unsigned IDLE_STOP_BIT = 13;
  localparam int unsigned SEL_BIT       = 7;
  localparam int unsigned RUN_BIT       = 6;
  localparam int unsigned UNLOCK_BIT    = 3;
  localparam int unsigned SYNC_BIT      = 2;
  localparam int unsigned HALF_BIT      = 1;
  localparam int unsigned OE_BIT        = 0;

  // seconds field of time_value
  localparam int unsigned SEC_LSB = 8;
  localparam int unsigned SEC_W   = 7;

  // values after power-on reset
  localparam logic [31:0]      CTRL_RESET = 32'h0000_0000;
  localparam logic [CAL_W-1:0] CAL_RESET  = 10'h000;
  localparam logic [SEC_W-1:0] SEC_RESET  = 7'h00;
  localparam logic [15:0]      PRE_RESET  = 16'h0000;
  localparam logic [9:0]       SKIP_RESET = 10'h000;

  // implemented positions of rtc_control; all others read zero
  localparam logic [31:0] CTRL_IMPL_MASK = 32'h03FF_A0CF;

  // cycle and pulse counts
  localparam logic [SEC_W-1:0] SEC_LAST  = 7'h3B;
  localparam int unsigned      SYNC_WIN  = 32;
  localparam int unsigned      PPS_DEF   = 32768;

  // apb request and answer
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } calendar_clock_module_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } calendar_clock_module_apb_rsp_s;

  // prescaler phase: counting, or eating pulses for a negative trim
  typedef enum logic [1:0] {
    TK_COUNT = 2'b01,
    TK_SKIP  = 2'b10
  } calendar_clock_module_tk_e;

endpackage

//--- test/calendar_clock_module_control_props.sv
module calendar_clock_module_control_props
  import calendar_clock_module_pkg::*;
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire calendar_clock_module_apb_req_s apb_req,
  input wire calendar_clock_module_apb_rsp_s apb_rsp,
  input wire logic          tk_clk_pin,
  input wire logic          idle_mode,
  input wire logic          unlock_seq_en,
  input wire logic          alarm_pulse,
  input wire logic          bus_clk_en,
  input wire logic          module_on,
  input wire logic          rtc_pin_out,
  input wire logic          rtc_pin_drive
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // access decode, shared by the properties below
  wire acc     = apb_req.psel & apb_req.penable;
  wire is_ctrl = apb_req.paddr == CALENDAR_CLOCK_MODULE_CTRL_OFS;
  wire mapped  = is_ctrl | (apb_req.paddr == CALENDAR_CLOCK_MODULE_TIME_OFS);
  wire ctrl_wr = acc & apb_req.pwrite & is_ctrl;

  sequence acc_s;
    acc;
  endsequence
  sequence ctrl_wr_s;
    ctrl_wr;
  endsequence

  ready_always_a: assert property (acc_s |-> apb_rsp.pready)
    else $error("pready low in access");
  unmapped_err_a: assert property (acc_s ##0 !mapped |->
    apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc_s ##0 mapped |-> !apb_rsp.pslverr)
    else $error("error on mapped access");
  reserved_zero_a: assert property (
    acc_s ##0 !apb_req.pwrite && is_ctrl |->
    (apb_rsp.prdata & ~CTRL_IMPL_MASK) == 32'h0000_0000)
    else $error("reserved bit reads one");
  idle_run_a: assert property (!idle_mode |=> bus_clk_en)
    else $error("bus clock cut outside idle");
  pin_gate_a: assert property (rtc_pin_out |-> rtc_pin_drive)
    else $error("pin active without enable");
  oe_follow_a: assert property (ctrl_wr_s |-> ##2
    rtc_pin_drive == $past(apb_req.pwdata[OE_BIT], 2))
    else $error("pin drive does not follow enable bit");
  // the enable only rises from a control write or the end of a clock cut
  enable_cause_a: assert property ($rose(module_on) |->
    $past(ctrl_wr && apb_req.pwdata[ON_BIT]) || $past(idle_mode) ||
    $past(idle_mode, 2) || $past(!bus_clk_en))
    else $error("module started without cause");
endmodule

bind calendar_clock_module_control calendar_clock_module_control_props u_calendar_clock_module_control_props (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .tk_clk_pin(tk_clk_pin), .idle_mode(idle_mode),
  .unlock_seq_en(unlock_seq_en), .alarm_pulse(alarm_pulse),
  .bus_clk_en(bus_clk_en), .module_on(module_on),
  .rtc_pin_out(rtc_pin_out), .rtc_pin_drive(rtc_pin_drive)
);

//--- test/rtc_control_calibration_bench.sv
module rtc_control_calibration_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import calendar_clock_module_pkg::*;

  logic          pclk    = 1'b0;
  logic          presetn = 1'b0;
  calendar_clock_module_apb_req_s req     = '0;
  calendar_clock_module_apb_rsp_s rsp;
  logic          tk = 1'b0, idle = 1'b0, seq_en = 1'b0, alarm = 1'b0;
  logic          clk_en, on, pin, drive;
  logic [31:0]   q;
  logic          err;
  int            fails = 0, n_tests = 0;

  // 40 mhz clock
  initial forever #12.5 pclk = ~pclk;

  // small pulse count per second keeps a minute short in simulation
  calendar_clock_module_control #(.PULSES_PER_SEC(16)) u_calendar_clock_module_control (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .tk_clk_pin(tk), .idle_mode(idle), .unlock_seq_en(seq_en),
    .alarm_pulse(alarm), .bus_clk_en(clk_en), .module_on(on),
    .rtc_pin_out(pin), .rtc_pin_drive(drive)
  );

  task automatic print_verdict;
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // one apb transfer, then an idle cycle so psel never toggles in one step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    q = rsp.prdata;
    err = rsp.pslverr;
    chk(32'(rsp.pready), 32'h0000_0001); // wait limit or ready lost
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask

  // pulses on the timekeeping input until the pin reaches lvl
  task automatic cnt(input logic lvl, input int e);
    int n;
    n = 0;
    do begin
      tk <= 1'b1;
      repeat (4) @(posedge pclk);
      tk <= 1'b0;
      repeat (4) @(posedge pclk);
      n++;
    end while (pin !== lvl && n < 600);
    chk(32'(n), 32'(e));
  endtask

  task automatic t_lock;
    rd(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_0000);
    wr(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_8008);
    rd(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    chk(q, 32'h0000_0000);
    seq_en <= 1'b1;
    wr(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_0008);
    wr(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_8008);
    rd(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_8048);
    chk(32'(on), 32'h0000_0001);
    // idle cycle after clearing the enable
    wr(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_0008);
    rd(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_0008);
  endtask

  task automatic t_bits;
    wr(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'hFFFF_FFFF);
    rd(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h03FF_A0C9);
    wr(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_0008);
  endtask

  task automatic t_idle;
    wr(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_A008);
    idle <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'({clk_en, on}), 32'h0000_0000);
    rd(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_A008);
    wr(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_8008);
    repeat (2) @(posedge pclk);
    chk(32'({clk_en, on}), 32'h0000_0003);
    idle <= 1'b0;
  endtask

  task automatic t_pin;
    wr(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_0009);
    alarm <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'({pin, drive}), 32'h0000_0003);
    alarm <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'({pin, drive}), 32'h0000_0001);
    alarm <= 1'b1;
    wr(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_0008);
    repeat (2) @(posedge pclk);
    chk(32'({pin, drive}), 32'h0000_0000);
    alarm <= 1'b0;
  endtask

  task automatic t_trim;
    logic [9:0] trim [4] = '{10'h000, 10'h002, 10'h3FD, 10'h200};
    int         ex   [4] = '{8, 6, 11, 520};
    wr(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_8089);
    wr(CALENDAR_CLOCK_MODULE_TIME_OFS, 32'h0000_3B00);
    cnt(1'b1, 8);
    wr(CALENDAR_CLOCK_MODULE_TIME_OFS, 32'h0000_3B00);
    rd(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_80C9);
    for (int i = 0; i < 4; i++) begin
      wr(CALENDAR_CLOCK_MODULE_CTRL_OFS, {6'h00, trim[i], 16'h8089});
      wr(CALENDAR_CLOCK_MODULE_TIME_OFS, 32'h0000_3B00);
      cnt(1'b1, 8);
      cnt(1'b0, 8);
      cnt(1'b1, ex[i]);
      cnt(1'b0, 8);
    end
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_lock;
    t_bits;
    t_idle;
    t_pin;
    t_trim;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CALENDAR_CLOCK_MODULE_CTRL_OFS, 32'h0000_0000);
    print_verdict;
  end

  // tests need about 5300 cycles
  initial begin
    repeat (30000) @(posedge pclk);
    fails++;
    print_verdict;
  end
endmodule
